// [rtl/atatc_defines.svh]
`ifndef ATATC_DEFINES_SVH
`define ATATC_DEFINES_SVH

// Register byte offsets
`define ATATC_OFF_WAKE   8'h1C
`define ATATC_OFF_ALM_A  8'h20
`define ATATC_OFF_ALM_B  8'h24
`define ATATC_OFF_TAP_A  8'h30
`define ATATC_OFF_TAP_B  8'h34
`define ATATC_OFF_STAT   8'h3C
`define ATATC_OFF_CLK    8'h40
`define ATATC_OFF_TRIM   8'h44
`define ATATC_OFF_ARM    8'h48
`define ATATC_OFF_DISARM 8'h4C
`define ATATC_OFF_MASK   8'h50

// Event bit positions shared by wake, arm, disarm and mask words
`define ATATC_BIT_WRAP 0
`define ATATC_BIT_AL0  8
`define ATATC_BIT_AL1  9
`define ATATC_BIT_INTERVAL_TICK_A 16
`define ATATC_BIT_INTERVAL_TICK_B 17

// Field positions
`define ATATC_TAP_LSB   0
`define ATATC_TAP_MSB   4
`define ATATC_CEN_BIT   0
`define ATATC_SRC_LSB   8
`define ATATC_SRC_MSB   10
`define ATATC_SHIFT_LSB 0
`define ATATC_SHIFT_MSB 4
`define ATATC_ADD_BIT   5
`define ATATC_VAL_LSB   8
`define ATATC_VAL_MSB   15
`define ATATC_STAT_SYNC 0
`define ATATC_STAT_CLKB 1

// Prescaler source codes
`define ATATC_SRC_SYS_RC    3'h0
`define ATATC_SRC_SLOW_XTAL 3'h1
`define ATATC_SRC_BUS       3'h2
`define ATATC_SRC_GENERIC   3'h3
`define ATATC_SRC_KHZ       3'h4

// Reset values
`define ATATC_RST_WORD 32'h0000_0000
`define ATATC_RST_TAP  5'h00
`define ATATC_RST_SRC  3'h0

// Timing and tuner constants
`define ATATC_CLK_SYNC_CYCLES 8
`define ATATC_TRIM_NUM        9'h100

`endif

// [rtl/atatc_pkg.sv]
package atatc_pkg;

  // One flag per event source, in register bit order
  typedef struct packed {
    logic interval_tick_b;
    logic interval_tick_a;
    logic al1;
    logic al0;
    logic wrap;
  } atatc_evt_t;

  // Tuner settings
  typedef struct packed {
    logic [7:0] value;
    logic       add;
    logic [4:0] shift;
  } atatc_trim_t;

  // Bus answer sequencing
  typedef enum logic {
    BUS_IDLE   = 1'h0,
    BUS_ANSWER = 1'h1
  } atatc_bus_st_t;

endpackage

// [rtl/atatc_tap_edge.sv]
`timescale 1ns/10ps
`include "atatc_defines.svh"
module atatc_tap_edge #(
  parameter int TAP_BITS = 32
) (
  // Clock and control
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                ce,
  // Synchronised prescaler bits and the chosen tap
  input  wire logic [TAP_BITS-1:0] tap_bits,
  input  wire logic [4:0]          tap_select,
  // Rising-edge pulse on the chosen bit
  output logic                     tick
);

  logic tap_now;
  logic tap_prev_reg;
  logic tick_reg;

  // Taps beyond the implemented prescaler width read as constant low
  assign tap_now = (32'(tap_select) < TAP_BITS) ? tap_bits[tap_select] : 1'b0;

  // Edge detect; a change of tap may give one spurious edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_prev_reg <= 1'b0;
      tick_reg     <= 1'b0;
    end else if (ce) begin
      tap_prev_reg <= tap_now;
      tick_reg     <= tap_now & ~tap_prev_reg;
    end
  end

  assign tick = tick_reg;

  a_tap_rise: assert property (@(posedge clk) disable iff (!rst_n)
    ce && tap_now && !tap_prev_reg |=> tick)
    else $error("Tap rise gave no tick");

  a_tap_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !(tap_now && !tap_prev_reg) |=> !tick)
    else $error("Tick without tap rise");

endmodule

// [rtl/atatc_top.sv]
`timescale 1ns/10ps
`include "atatc_defines.svh"
module atatc_top #(
  parameter int CLK_SYNC_CYCLES = `ATATC_CLK_SYNC_CYCLES,
  parameter int TAP_BITS        = 32
) (
  // Clock, reset and enable
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                ce,
  // Avalon-MM slave
  input  wire logic [7:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  // Timer unit
  input  wire logic [31:0]         counter_value,
  input  wire logic                counter_wrap,
  input  wire logic [TAP_BITS-1:0] prescaler_bits,
  input  wire logic                sync_pending,
  input  wire logic                prescaler_tick,
  // Prescaler clock control and tuned tick
  output logic                     prescaler_clock_on,
  output logic [4:0]               prescaler_source_sel,
  output logic                     clock_change_pending,
  output logic                     tuned_tick,
  // Wake and events
  output logic                     wake_request,
  output atatc_pkg::atatc_evt_t    event_flags,
  output atatc_pkg::atatc_evt_t    trigger_out
);

  localparam int CW = $clog2(CLK_SYNC_CYCLES + 1);
  localparam logic [CW-1:0] SYNC_LOAD = CW'(CLK_SYNC_CYCLES - 1);

  // Refuse settings the logic cannot serve
  if (TAP_BITS < 2 || TAP_BITS > 32) begin : g_bad_taps
    $error("TAP_BITS must be 2 to 32");
  end
  if (CLK_SYNC_CYCLES < 1) begin : g_bad_sync
    $error("CLK_SYNC_CYCLES must be at least 1");
  end

  // Place event flags at their register bit positions
  function automatic logic [31:0] evt_word(input atatc_pkg::atatc_evt_t e);
    logic [31:0] w;
    w = `ATATC_RST_WORD;
    w[`ATATC_BIT_WRAP] = e.wrap;
    w[`ATATC_BIT_AL0]  = e.al0;
    w[`ATATC_BIT_AL1]  = e.al1;
    w[`ATATC_BIT_INTERVAL_TICK_A] = e.interval_tick_a;
    w[`ATATC_BIT_INTERVAL_TICK_B] = e.interval_tick_b;
    return w;
  endfunction

  function automatic atatc_pkg::atatc_evt_t word_evt(input logic [31:0] w);
    return '{interval_tick_b: w[`ATATC_BIT_INTERVAL_TICK_B], interval_tick_a: w[`ATATC_BIT_INTERVAL_TICK_A],
             al1: w[`ATATC_BIT_AL1], al0: w[`ATATC_BIT_AL0],
             wrap: w[`ATATC_BIT_WRAP]};
  endfunction

  // Byte-enable expansion
  function automatic logic [31:0] be_bits(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  atatc_pkg::atatc_bus_st_t bus_st_reg;
  logic                     wait_reg;
  logic [31:0]              rdata_reg;
  logic [31:0]              rd_word;
  logic [7:0]               addr_w;
  logic [31:0]              wmask;
  logic [31:0]              wdata_m;
  logic                     wr_go;
  logic                     wr_ok;
  logic                     clk_wr;
  atatc_pkg::atatc_evt_t    wake_en_reg;
  atatc_pkg::atatc_evt_t    mask_reg;
  atatc_pkg::atatc_evt_t    flags;
  atatc_pkg::atatc_evt_t    trig_reg;
  logic [31:0]              alarm_reg [2];
  logic [4:0]               tap_reg [2];
  logic [31:0]              cnt_prev_reg;
  logic [1:0]               hit_reg;
  logic                     wrap_reg;
  logic [1:0]               tick;
  logic                     wake_reg;
  logic                     clk_on_reg;
  logic [2:0]               src_reg;
  logic [4:0]               src_sel_reg;
  logic                     clk_busy_reg;
  logic [CW-1:0]            clk_cnt_reg;
  atatc_pkg::atatc_trim_t   trim_reg;
  logic [8:0]               trim_div;
  logic [39:0]              period;
  logic [39:0]              trim_cnt_reg;
  logic                     extra_reg;
  logic                     tuned_reg;
  logic [TAP_BITS-1:0]      presc_s1_reg;
  logic [TAP_BITS-1:0]      presc_s2_reg;

  assign addr_w  = {avs_address[7:2], 2'h0};
  assign wmask   = be_bits(avs_byteenable);
  assign wdata_m = avs_writedata & wmask;
  // A write takes effect at the edge where the master sees waitrequest low
  assign wr_go   = avs_write && (bus_st_reg == atatc_pkg::BUS_ANSWER) && ce;
  assign wr_ok   = wr_go && !sync_pending;
  // Clock control changes only while no earlier change is in flight
  assign clk_wr  = wr_go && (addr_w == `ATATC_OFF_CLK) && !clk_busy_reg;

  // Bus answer: one wait cycle, then one cycle with waitrequest low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_st_reg <= atatc_pkg::BUS_IDLE;
      wait_reg   <= 1'b1;
      rdata_reg  <= `ATATC_RST_WORD;
    end else if (ce) begin
      unique case (bus_st_reg)
        atatc_pkg::BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_st_reg <= atatc_pkg::BUS_ANSWER;
            wait_reg   <= 1'b0;
            rdata_reg  <= avs_read ? rd_word : `ATATC_RST_WORD;
          end
        end
        atatc_pkg::BUS_ANSWER: begin
          bus_st_reg <= atatc_pkg::BUS_IDLE;
          wait_reg   <= 1'b1;
        end
      endcase
    end
  end

  // Read mux; protected registers read zero while sync is pending
  always_comb begin
    rd_word = `ATATC_RST_WORD;
    case (addr_w)
      `ATATC_OFF_WAKE:  rd_word = evt_word(wake_en_reg);
      `ATATC_OFF_ALM_A: rd_word = alarm_reg[0];
      `ATATC_OFF_ALM_B: rd_word = alarm_reg[1];
      `ATATC_OFF_TAP_A: rd_word[`ATATC_TAP_MSB:`ATATC_TAP_LSB] = tap_reg[0];
      `ATATC_OFF_TAP_B: rd_word[`ATATC_TAP_MSB:`ATATC_TAP_LSB] = tap_reg[1];
      `ATATC_OFF_TRIM: begin
        rd_word[`ATATC_VAL_MSB:`ATATC_VAL_LSB]     = trim_reg.value;
        rd_word[`ATATC_ADD_BIT]                    = trim_reg.add;
        rd_word[`ATATC_SHIFT_MSB:`ATATC_SHIFT_LSB] = trim_reg.shift;
      end
      `ATATC_OFF_CLK: begin
        rd_word[`ATATC_CEN_BIT]                = clk_on_reg;
        rd_word[`ATATC_SRC_MSB:`ATATC_SRC_LSB] = src_reg;
      end
      `ATATC_OFF_MASK: rd_word = evt_word(mask_reg);
      `ATATC_OFF_STAT: begin
        rd_word[`ATATC_STAT_SYNC] = sync_pending;
        rd_word[`ATATC_STAT_CLKB] = clk_busy_reg;
      end
      default: rd_word = `ATATC_RST_WORD;
    endcase
    if (sync_pending && addr_w != `ATATC_OFF_CLK && addr_w != `ATATC_OFF_STAT &&
        addr_w != `ATATC_OFF_MASK) begin
      rd_word = `ATATC_RST_WORD;
    end
  end

  // Wake enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_en_reg <= '0;
    end else if (wr_ok && addr_w == `ATATC_OFF_WAKE) begin
      wake_en_reg <= word_evt((evt_word(wake_en_reg) & ~wmask) | wdata_m);
    end
  end

  // Alarm compare values and tap selects
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_reg[0] <= `ATATC_RST_WORD;
      alarm_reg[1] <= `ATATC_RST_WORD;
      tap_reg[0]   <= `ATATC_RST_TAP;
      tap_reg[1]   <= `ATATC_RST_TAP;
    end else if (wr_ok) begin
      for (int i = 0; i < 2; i++) begin
        if (addr_w == `ATATC_OFF_ALM_A + 8'(4 * i)) begin
          alarm_reg[i] <= (alarm_reg[i] & ~wmask) | wdata_m;
        end
        if (addr_w == `ATATC_OFF_TAP_A + 8'(4 * i) && avs_byteenable[0]) begin
          tap_reg[i] <= avs_writedata[`ATATC_TAP_MSB:`ATATC_TAP_LSB];
        end
      end
    end
  end

  // Clock control with busy window; settling time is a parameter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_on_reg   <= 1'b0;
      src_reg      <= `ATATC_RST_SRC;
      src_sel_reg  <= 5'h00;
      clk_busy_reg <= 1'b0;
      clk_cnt_reg  <= '0;
    end else if (clk_wr) begin
      if (avs_byteenable[0]) begin
        clk_on_reg <= avs_writedata[`ATATC_CEN_BIT];
      end
      if (avs_byteenable[1]) begin
        src_reg <= avs_writedata[`ATATC_SRC_MSB:`ATATC_SRC_LSB];
        case (avs_writedata[`ATATC_SRC_MSB:`ATATC_SRC_LSB])
          `ATATC_SRC_SYS_RC:    src_sel_reg <= 5'h01;
          `ATATC_SRC_SLOW_XTAL: src_sel_reg <= 5'h02;
          `ATATC_SRC_BUS:       src_sel_reg <= 5'h04;
          `ATATC_SRC_GENERIC:   src_sel_reg <= 5'h08;
          `ATATC_SRC_KHZ:       src_sel_reg <= 5'h10;
          default:              src_sel_reg <= 5'h00; // Reserved codes pick nothing
        endcase
      end
      clk_busy_reg <= 1'b1;
      clk_cnt_reg  <= SYNC_LOAD;
    end else if (ce && clk_busy_reg) begin
      if (clk_cnt_reg == '0) begin
        clk_busy_reg <= 1'b0;
      end else begin
        clk_cnt_reg <= clk_cnt_reg - CW'(1);
      end
    end
  end

  // Tuner settings
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_reg <= '0;
    end else if (wr_ok && addr_w == `ATATC_OFF_TRIM) begin
      if (avs_byteenable[0]) begin
        trim_reg.add   <= avs_writedata[`ATATC_ADD_BIT];
        trim_reg.shift <= avs_writedata[`ATATC_SHIFT_MSB:`ATATC_SHIFT_LSB];
      end
      if (avs_byteenable[1]) begin
        trim_reg.value <= avs_writedata[`ATATC_VAL_MSB:`ATATC_VAL_LSB];
      end
    end
  end

  // Event mask: arm sets, disarm clears, zero bits leave it alone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= '0;
    end else if (wr_ok && addr_w == `ATATC_OFF_ARM) begin
      mask_reg <= word_evt(evt_word(mask_reg) | wdata_m);
    end else if (wr_ok && addr_w == `ATATC_OFF_DISARM) begin
      mask_reg <= word_evt(evt_word(mask_reg) & ~wdata_m);
    end
  end

  // Prescaler bits come from the prescaler clock domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_s1_reg <= '0;
      presc_s2_reg <= '0;
    end else if (ce) begin
      presc_s1_reg <= prescaler_bits;
      presc_s2_reg <= presc_s1_reg;
    end
  end

  // Periodic tap edge detectors
  for (genvar g = 0; g < 2; g++) begin : g_tap
    atatc_tap_edge #(
      .TAP_BITS (TAP_BITS)
    ) u_tap (
      .clk        (clk),
      .rst_n      (rst_n),
      .ce         (ce),
      .tap_bits   (presc_s2_reg),
      .tap_select (tap_reg[g]),
      .tick       (tick[g])
    );
  end

  // Alarm hits fire only when the counter moves onto the value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_prev_reg <= `ATATC_RST_WORD;
      hit_reg      <= 2'h0;
      wrap_reg     <= 1'b0;
    end else if (ce) begin
      cnt_prev_reg <= counter_value;
      for (int i = 0; i < 2; i++) begin
        hit_reg[i] <= (counter_value == alarm_reg[i]) &&
                      (counter_value != cnt_prev_reg);
      end
      wrap_reg <= counter_wrap;
    end
  end

  assign flags = '{interval_tick_b: tick[1], interval_tick_a: tick[0], al1: hit_reg[1], al0: hit_reg[0],
                   wrap: wrap_reg};

  // Wake request and armed event outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_reg <= 1'b0;
      trig_reg <= '0;
    end else if (ce) begin
      wake_reg <= |(flags & wake_en_reg);
      trig_reg <= flags & mask_reg;
    end
  end

  // Tuner period: roundup(256 / value) shifted by the exponent
  assign trim_div = (trim_reg.value == 8'h00) ? 9'h000 :
                    9'((`ATATC_TRIM_NUM + {1'b0, trim_reg.value} - 9'h001) /
                       {1'b0, trim_reg.value});
  assign period   = {31'h0000_0000, trim_div} << trim_reg.shift;

  // Tuned tick; an inserted tick needs one idle cycle after its input tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_cnt_reg <= 40'h00_0000_0000;
      extra_reg    <= 1'b0;
      tuned_reg    <= 1'b0;
    end else if (ce) begin
      if (trim_reg.value == 8'h00) begin
        tuned_reg    <= prescaler_tick;
        trim_cnt_reg <= 40'h00_0000_0000;
        extra_reg    <= 1'b0;
      end else if (!trim_reg.add) begin
        extra_reg <= 1'b0;
        if (prescaler_tick && trim_cnt_reg >= period) begin
          tuned_reg    <= 1'b0;
          trim_cnt_reg <= 40'h00_0000_0000;
        end else begin
          tuned_reg    <= prescaler_tick;
          trim_cnt_reg <= trim_cnt_reg + 40'(prescaler_tick);
        end
      end else if (prescaler_tick) begin
        tuned_reg <= 1'b1;
        if (trim_cnt_reg + 40'h00_0000_0001 >= period - 40'h00_0000_0001) begin
          extra_reg    <= 1'b1;
          trim_cnt_reg <= 40'h00_0000_0000;
        end else begin
          trim_cnt_reg <= trim_cnt_reg + 40'h00_0000_0001;
        end
      end else begin
        tuned_reg <= extra_reg;
        extra_reg <= 1'b0;
      end
    end
  end

  assign avs_readdata         = rdata_reg;
  assign avs_waitrequest      = wait_reg;
  assign prescaler_clock_on   = clk_on_reg;
  assign prescaler_source_sel = src_sel_reg;
  assign clock_change_pending = clk_busy_reg;
  assign tuned_tick           = tuned_reg;
  assign wake_request         = wake_reg;
  assign event_flags          = flags;
  assign trigger_out          = trig_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_busy_read;
    ce && bus_st_reg == atatc_pkg::BUS_IDLE && avs_read && sync_pending &&
    addr_w == `ATATC_OFF_ALM_B;
  endsequence

  sequence s_fast_wrap;
    ce && trim_reg.value != 8'h00 && trim_reg.add && prescaler_tick &&
    trim_cnt_reg + 40'h00_0000_0001 >= period - 40'h00_0000_0001;
  endsequence

  a_wake_periodic: assert property (ce && flags.interval_tick_a && wake_en_reg.interval_tick_a |=> wake_reg)
    else $error("Enabled periodic tick gave no wake");
  a_wake_alarm: assert property (ce && flags.al0 && wake_en_reg.al0 |=> wake_reg)
    else $error("Enabled alarm gave no wake");
  a_wake_quiet: assert property (ce && (flags & wake_en_reg) == '0 |=> !wake_reg)
    else $error("Wake without an enabled event");
  a_alarm_reach: assert property (ce && counter_value == alarm_reg[1] &&
    counter_value != cnt_prev_reg |=> hit_reg[1] && flags.al1)
    else $error("Alarm value reached without hit");
  a_busy_drop: assert property (wr_go && sync_pending &&
    addr_w == `ATATC_OFF_ALM_A |=> $stable(alarm_reg[0]))
    else $error("Write taken while sync pending");
  a_busy_read: assert property (s_busy_read |=> avs_readdata == 32'h0000_0000)
    else $error("Protected read not zero while busy");
  a_arm_set: assert property (wr_ok && addr_w == `ATATC_OFF_ARM &&
    avs_byteenable[0] && avs_writedata[`ATATC_BIT_WRAP] |=> mask_reg.wrap)
    else $error("Arm write did not set mask");
  a_disarm_clear: assert property (wr_ok && addr_w == `ATATC_OFF_DISARM &&
    avs_byteenable[2] && avs_writedata[`ATATC_BIT_INTERVAL_TICK_B] |=> !mask_reg.interval_tick_b)
    else $error("Disarm write did not clear mask");
  a_clk_busy: assert property (clk_wr |=> clock_change_pending)
    else $error("Clock write did not show busy");
  a_clk_done: assert property (ce && clk_busy_reg && clk_cnt_reg == '0 && !clk_wr
    |=> !clock_change_pending)
    else $error("Clock busy did not end");
  a_src_khz: assert property (clk_wr && avs_byteenable[1] &&
    avs_writedata[`ATATC_SRC_MSB:`ATATC_SRC_LSB] == `ATATC_SRC_KHZ |=>
    prescaler_source_sel == 5'h10)
    else $error("kHz source not selected");
  a_clk_gate: assert property (clk_wr && avs_byteenable[0] |=>
    prescaler_clock_on == $past(avs_writedata[`ATATC_CEN_BIT]))
    else $error("Clock-on bit not applied");
  a_trim_pass: assert property (ce && trim_reg.value == 8'h00 && prescaler_tick
    |=> tuned_tick)
    else $error("Untuned tick lost");
  a_trim_slow: assert property (ce && trim_reg.value != 8'h00 && !trim_reg.add &&
    prescaler_tick && trim_cnt_reg >= period |=> !tuned_tick)
    else $error("Slow tuner did not drop a tick");
  a_trim_fast: assert property (s_fast_wrap ##1 (ce && !prescaler_tick)
    |=> tuned_tick)
    else $error("Fast tuner did not insert a tick");

endmodule

// [dv/atatc_unit_model.sv]
`timescale 1ns/10ps
// Stand-in for the counter and prescaler of the timer unit
module atatc_unit_model #(
  parameter logic [31:0] START = 32'hFFFF_C000
) (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // Timer unit outputs
  output logic [31:0] counter_value,
  output logic        counter_wrap,
  output logic [31:0] prescaler_bits,
  output logic        prescaler_tick
);
  // Steps every cycle so alarm, wrap and tap times are easy to predict
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_value <= START;
      counter_wrap  <= 1'b0;
    end else begin
      counter_value <= counter_value + 32'h0000_0001;
      counter_wrap  <= (counter_value == 32'hFFFF_FFFF);
    end
  end
  // Prescaler bits follow the counter; tick every fourth cycle
  assign prescaler_bits = counter_value;
  assign prescaler_tick = (counter_value[1:0] == 2'h3);
endmodule

// [dv/tb_top.sv]
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin errors++; \
  $display("Error %s expected %h seen %h", nm, e, s); end end
module tb_top;
  logic                  clk = 1'b0, rst_n = 1'b0, ce = 1'b1, sync_pending = 1'b0;
  logic                  avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [7:0]            avs_address = 8'h00;
  logic [3:0]            avs_byteenable = 4'hF;
  logic [31:0]           avs_writedata = 32'h0000_0000, avs_readdata, t, a, b;
  logic [31:0]           counter_value, prescaler_bits, exp_q[$];
  logic                  counter_wrap, prescaler_tick, prescaler_clock_on, cnt_en = 1'b0;
  logic                  clock_change_pending, tuned_tick, wake_request;
  logic [4:0]            prescaler_source_sel;
  logic [7:0]            offs[9] = '{8'h1C, 8'h20, 8'h24, 8'h30, 8'h34, 8'h40, 8'h44, 8'h50, 8'h60};
  atatc_pkg::atatc_evt_t event_flags, trigger_out;
  int                    errors = 0, n_tests = 0, n[7], s;
  atatc_top #(.CLK_SYNC_CYCLES(2)) i_atatc_top (.clk, .rst_n, .ce, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .counter_value, .counter_wrap, .prescaler_bits, .sync_pending, .prescaler_tick,
    .prescaler_clock_on, .prescaler_source_sel, .clock_change_pending, .tuned_tick,
    .wake_request, .event_flags, .trigger_out);
  atatc_unit_model i_atatc_unit_model (.clk, .rst_n, .counter_value, .counter_wrap,
    .prescaler_bits, .prescaler_tick);
  always #2 clk = ~clk;
  task automatic complete_run();
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    avs_address <= ad;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Expected read data is noted before the request goes out
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, ad, 32'h0000_0000);
  endtask
  // Counts event pulses over a window of cycles
  task automatic count(input int c);
    n = '{default: 0};
    cnt_en <= 1'b1;
    repeat (c) @(posedge clk);
    cnt_en <= 1'b0;
    @(posedge clk);
  endtask
  // Unknown levels count as pulses, so they cannot slip through as zero
  always @(posedge clk) if (cnt_en) begin
    n[0] += int'(wake_request !== 1'b0);
    n[1] += int'(event_flags.al0 !== 1'b0);
    n[2] += int'(event_flags.al1 !== 1'b0);
    n[3] += int'(trigger_out.al1 !== 1'b0);
    n[4] += int'(event_flags.interval_tick_a !== 1'b0);
    n[5] += int'(event_flags.interval_tick_b !== 1'b0);
    n[6] += int'(tuned_tick !== 1'b0);
  end
  // Read data checked at the edge that ends each read
  always @(posedge clk) if (avs_read && avs_waitrequest === 1'b0) begin
    t = exp_q.pop_front();
    `CHK("readdata", t, avs_readdata)
  end
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    complete_run();
  end
  initial begin
    void'($urandom(32'hf7d9));
    a = $urandom;
    b = $urandom;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    foreach (offs[i]) rd(offs[i], 32'h0000_0000);
    bus(1'b1, 8'h20, a);
    bus(1'b1, 8'h24, b);
    rd(8'h20, a);
    rd(8'h24, b);
    // Writes while busy are dropped and reads give zero
    sync_pending <= 1'b1;
    bus(1'b1, 8'h20, ~a);
    bus(1'b1, 8'h48, 32'h0003_0301);
    rd(8'h24, 32'h0000_0000);
    sync_pending <= 1'b0;
    rd(8'h20, a);
    rd(8'h50, 32'h0000_0000);
    bus(1'b1, 8'h48, 32'h0003_0301);
    bus(1'b1, 8'h4C, 32'h0002_0001);
    bus(1'b1, 8'h48, 32'h0000_0000);
    rd(8'h50, 32'h0001_0300);
    // Alarm A wakes, alarm B only flags and triggers
    bus(1'b1, 8'h1C, 32'h0000_0100);
    bus(1'b1, 8'h20, counter_value + 32'h0000_00C8);
    bus(1'b1, 8'h24, counter_value + 32'h0000_00FA);
    count(400);
    `CHK("alarm wakes", 1, n[0])
    `CHK("alarm a hits", 1, n[1])
    `CHK("alarm b hits", 1, n[2])
    `CHK("alarm b trigger", 1, n[3])
    // Periodic taps: eight rises of the chosen bit per window
    s = 3 + $urandom % 3;
    bus(1'b1, 8'h30, 32'(s));
    bus(1'b1, 8'h34, 32'(s));
    bus(1'b1, 8'h1C, 32'h0001_0000);
    @(posedge clk); // New enables must reach the first counted wake
    count(16 << s);
    `CHK("periodic wakes", 8, n[0])
    `CHK("periodic a", 8, n[4])
    `CHK("periodic b", 8, n[5])
    // Every source code, with the gate alternating
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, 8'h40, (32'(k) << 8) | 32'(k % 2));
      @(posedge clk);
      #1;
      `CHK("source", 5'h01 << k, prescaler_source_sel)
      `CHK("gate", 1'(k % 2), prescaler_clock_on)
      `CHK("clock busy", 1'b1, clock_change_pending)
      while (clock_change_pending !== 1'b0) @(posedge clk);
      rd(8'h40, (32'(k) << 8) | 32'(k % 2));
    end
    // Tuner: 12 input ticks per window; plain, two in three, four in three
    count(48);
    `CHK("tuned plain", 12, n[6])
    bus(1'b1, 8'h44, 32'h0000_8000);
    repeat (12) @(posedge clk); // Skip the first group so the window is steady
    count(48);
    `CHK("tuned slow", 8, n[6])
    bus(1'b1, 8'h44, 32'h0000_0000);
    bus(1'b1, 8'h44, 32'h0000_8021);
    repeat (12) @(posedge clk);
    count(48);
    `CHK("tuned fast", 16, n[6])
    rd(8'h44, 32'h0000_8021);
    // Counter wrap wakes once when it is the only enabled source
    bus(1'b1, 8'h1C, 32'h0000_0001);
    while (counter_value < 32'hFFFF_FFC0) @(posedge clk);
    count(128);
    `CHK("wrap wakes", 1, n[0])
    complete_run();
  end
endmodule
